// *** hw/pll_ctrl_pkg.sv ***
// Behaviour
// - Reserved bits read zero, writes ignored
// - Stable flag low while oscillator counter runs
// - Stable high: count done, disabled, or test
// - Lock flag low while acquiring, resets low
// - Lock flag high once loop has locked
// - Loop reset bit holds loop, resets to one
// - Oscillator power-down bit, resets zero, requests
// - Clock mode zero: power down at idle entry
// - Clock mode one: power down immediately
// - Loop power-down bit stops loop, resets zero
// - Mode bit zero selects bypass reference path
// - Mode bit one selects loop output path
// - Multiplier field sets factor two to fifteen
package pll_ctrl_pkg;

    localparam int unsigned REG_W      = 16;
    localparam int unsigned MULT_W     = 5;

    localparam logic [15:0] CSR_OFFSET  = 16'h1C80;
    localparam logic [15:0] MULT_OFFSET = 16'h1C88;

    localparam int unsigned MODE_BIT     = 0;
    localparam int unsigned LOOP_PD_BIT  = 1;
    localparam int unsigned OSC_PD_BIT   = 2;
    localparam int unsigned LOOP_RST_BIT = 3;
    localparam int unsigned LOCK_BIT     = 5;
    localparam int unsigned STABLE_BIT   = 6;

    localparam logic MODE_RST     = 1'b0;
    localparam logic LOOP_PD_RST  = 1'b0;
    localparam logic OSC_PD_RST   = 1'b0;
    localparam logic LOOP_RST_RST = 1'b1;
    localparam logic [MULT_W-1:0] MULT_RST = 5'h00;

    localparam logic [MULT_W-1:0] MULT_MIN = 5'h02;
    localparam logic [MULT_W-1:0] MULT_MAX = 5'h0F;

    localparam int unsigned OSC_STABLE_CYCLES = 41032;
    localparam int unsigned LOCK_CYCLES_DEF   = 200;

    typedef enum logic [1:0] {
        OSC_RUN,
        OSC_ARMED,
        OSC_DOWN
    } osc_state_t;

endpackage

// *** hw/settle_timer.sv ***
`timescale 1ns/10ps
module settle_timer #(
    parameter int unsigned CYCLES = 16
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic run,
    output logic      done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire           atEnd;

    // Dropping run restarts the count from zero
    assign atEnd   = (cnt_r == LAST);
    assign cnt_nxt = !run  ? '0 :
                     atEnd ? cnt_r :
                     cnt_r + 1'b1;
    assign done    = atEnd & run;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// *** hw/pll_control_status_multiplier.sv ***
`timescale 1ns/10ps
module pll_control_status_multiplier
    import pll_ctrl_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = OSC_STABLE_CYCLES,
    parameter int unsigned LOCK_CYCLES   = LOCK_CYCLES_DEF
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [15:0]       regAddr,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    input  wire logic [REG_W-1:0]  regWrData,
    output logic      [REG_W-1:0]  regRdData,
    output logic                   regRdValid,
    input  wire logic              clockModeBit,
    input  wire logic              clockIdleStatus,
    input  wire logic              testMode,
    input  wire logic              oscCountDisable,
    output logic                   loopReset,
    output logic                   loopPowerDown,
    output logic                   oscPowerDown,
    output logic                   loopModeSelect,
    output logic      [MULT_W-1:0] multiplierSelect,
    output logic                   multiplierLegal,
    output logic                   oscStable,
    output logic                   loopLocked,
    output logic                   lockEvent
);

    // Software-written control state
    logic              modeSel_r;
    logic              loopPd_r;
    logic              oscPd_r;
    logic              loopRst_r;
    logic [MULT_W-1:0] mult_r;
    logic              multLegal_r;

    // Oscillator power sequencing
    osc_state_t        oscState_r;
    osc_state_t        oscState_nxt;
    logic              oscDown_r;
    logic              idlePrev_r;

    // Status flags
    logic              stable_r;
    logic              lock_r;
    logic              lockEvent_r;
    logic              multChanged_r;

    // Read port
    logic [REG_W-1:0]  rdData_r;
    logic              rdValid_r;

    // Address decode
    wire csrHit;
    wire multHit;
    wire csrWr;
    wire multWr;

    assign csrHit  = (regAddr == CSR_OFFSET);
    assign multHit = (regAddr == MULT_OFFSET);
    assign csrWr   = regWrEn & csrHit;
    assign multWr  = regWrEn & multHit;

    // Only the defined fields are captured; the rest of the
    // write word is dropped on the floor.
    wire              wrMode;
    wire              wrLoopPd;
    wire              wrOscPd;
    wire              wrLoopRst;
    wire [MULT_W-1:0] wrMult;

    assign wrMode    = regWrData[MODE_BIT];
    assign wrLoopPd  = regWrData[LOOP_PD_BIT];
    assign wrOscPd   = regWrData[OSC_PD_BIT];
    assign wrLoopRst = regWrData[LOOP_RST_BIT];
    assign wrMult    = regWrData[MULT_W-1:0];

    wire modeSel_nxt;
    wire loopPd_nxt;
    wire oscPd_nxt;
    wire loopRst_nxt;
    wire [MULT_W-1:0] mult_nxt;

    assign modeSel_nxt = csrWr  ? wrMode    : modeSel_r;
    assign loopPd_nxt  = csrWr  ? wrLoopPd  : loopPd_r;
    assign oscPd_nxt   = csrWr  ? wrOscPd   : oscPd_r;
    assign loopRst_nxt = csrWr  ? wrLoopRst : loopRst_r;
    assign mult_nxt    = multWr ? wrMult    : mult_r;

    // Bypass at 0, loop output at 1, feeding the divider mux
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modeSel_r <= MODE_RST;
        end else begin
            modeSel_r <= modeSel_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loopPd_r <= LOOP_PD_RST;
        end else begin
            loopPd_r <= loopPd_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscPd_r <= OSC_PD_RST;
        end else begin
            oscPd_r <= oscPd_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loopRst_r <= LOOP_RST_RST;
        end else begin
            loopRst_r <= loopRst_nxt;
        end
    end

    // Reserved codes are stored as written; software keeps
    // away from them, the legal flag only reports them.
    wire multInRange;

    assign multInRange = (mult_nxt >= MULT_MIN) &&
                         (mult_nxt <= MULT_MAX);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mult_r      <= MULT_RST;
            multLegal_r <= 1'b0;
        end else begin
            mult_r      <= mult_nxt;
            multLegal_r <= multInRange;
        end
    end

    // A new factor means a new frequency, so lock restarts
    wire multChange;

    assign multChange = multWr && (wrMult != mult_r);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            multChanged_r <= 1'b0;
        end else begin
            multChanged_r <= multChange;
        end
    end

    // Oscillator power-down sequencing
    wire idleRise;
    wire idleFall;

    assign idleRise = clockIdleStatus & ~idlePrev_r;
    assign idleFall = ~clockIdleStatus & idlePrev_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idlePrev_r <= 1'b0;
        end else begin
            idlePrev_r <= clockIdleStatus;
        end
    end

    // Clearing the request always wakes the oscillator. In
    // idle-driven mode, leaving idle also wakes it and re-arms.
    always_comb begin
        oscState_nxt = oscState_r;
        unique case (oscState_r)
            OSC_RUN: begin
                if (oscPd_r && clockModeBit) begin
                    oscState_nxt = OSC_DOWN;
                end else if (oscPd_r) begin
                    oscState_nxt = OSC_ARMED;
                end
            end
            OSC_ARMED: begin
                if (!oscPd_r) begin
                    oscState_nxt = OSC_RUN;
                end else if (clockModeBit) begin
                    oscState_nxt = OSC_DOWN;
                end else if (idleRise) begin
                    oscState_nxt = OSC_DOWN;
                end
            end
            OSC_DOWN: begin
                if (!oscPd_r) begin
                    oscState_nxt = OSC_RUN;
                end else if (!clockModeBit && idleFall) begin
                    oscState_nxt = OSC_ARMED;
                end
            end
            default: begin
                oscState_nxt = OSC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscState_r <= OSC_RUN;
        end else begin
            oscState_r <= oscState_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscDown_r <= 1'b0;
        end else begin
            oscDown_r <= (oscState_nxt == OSC_DOWN);
        end
    end

    // Stabilisation count restarts each time the oscillator
    // comes back from power-down.
    wire oscCountRun;
    wire oscCountDone;
    wire stable_nxt;

    assign oscCountRun = ~oscDown_r;

    settle_timer #(
        .CYCLES (STABLE_CYCLES)
    ) u_osc_timer (
        .clk  (clk),
        .nrst (nrst),
        .run  (oscCountRun),
        .done (oscCountDone)
    );

    assign stable_nxt = oscCountDone |
                        oscCountDisable |
                        testMode;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stable_r <= 1'b0;
        end else begin
            stable_r <= stable_nxt;
        end
    end

    // The loop acquires only with a running, stable reference,
    // out of reset and powered; any of those lost drops lock.
    wire lockRun;
    wire lockTimerRun;
    wire lockDone;
    wire lock_nxt;

    assign lockRun = ~loopRst_r & ~loopPd_r &
                     stable_r & ~oscDown_r;
    assign lockTimerRun = lockRun & ~multChanged_r;

    settle_timer #(
        .CYCLES (LOCK_CYCLES)
    ) u_lock_timer (
        .clk  (clk),
        .nrst (nrst),
        .run  (lockTimerRun),
        .done (lockDone)
    );

    assign lock_nxt = lockDone & lockRun;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lock_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    // One-cycle pulse as lock is gained, for polling-free use
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lockEvent_r <= 1'b0;
        end else begin
            lockEvent_r <= lock_nxt & ~lock_r;
        end
    end

    // Read path
    wire [REG_W-1:0] csrView;
    wire [REG_W-1:0] multView;
    wire [REG_W-1:0] rdMux;

    assign csrView = {9'h000, stable_r, lock_r, 1'b0,
                      loopRst_r, oscPd_r, loopPd_r, modeSel_r};
    assign multView = {11'h000, mult_r};
    assign rdMux = csrHit  ? csrView  :
                   multHit ? multView :
                   16'h0000;

    // Read data holds until the next read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_r  <= 16'h0000;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= regRdEn;
            if (regRdEn) begin
                rdData_r <= rdMux;
            end
        end
    end

    assign regRdData        = rdData_r;
    assign regRdValid       = rdValid_r;
    assign loopReset        = loopRst_r;
    assign loopPowerDown    = loopPd_r;
    assign oscPowerDown     = oscDown_r;
    assign loopModeSelect   = modeSel_r;
    assign multiplierSelect = mult_r;
    assign multiplierLegal  = multLegal_r;
    assign oscStable        = stable_r;
    assign loopLocked       = lock_r;
    assign lockEvent        = lockEvent_r;

endmodule

// *** dv/pll_ctrl_chk.sv ***
`timescale 1ns/10ps
module pll_ctrl_chk
    import pll_ctrl_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [15:0] regAddr,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic        clockModeBit,
    input wire logic        clockIdleStatus,
    input wire logic        testMode,
    input wire logic        oscCountDisable,
    input wire logic        loopReset,
    input wire logic        loopPowerDown,
    input wire logic        oscPowerDown,
    input wire logic        loopModeSelect,
    input wire logic        oscStable,
    input wire logic        loopLocked,
    input wire logic        lockEvent
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire csrWr = regWrEn && regAddr == CSR_OFFSET;
    wire csrRd = regRdEn && regAddr == CSR_OFFSET;
    wire badRd = regRdEn && regAddr != CSR_OFFSET && regAddr != MULT_OFFSET;
    property p_rsv_rd;
        csrRd |=> regRdData[15:7] == 9'h000 && !regRdData[4];
    endproperty
    a_rsv_rd: assert property (p_rsv_rd) else $error("reserved set");
    property p_bad_rd;
        badRd |=> regRdData == 16'h0000;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped data");
    property p_forced;
        testMode || oscCountDisable |=> oscStable;
    endproperty
    a_forced: assert property (p_forced) else $error("not forced");
    property p_stab_low;
        (oscPowerDown && !testMode && !oscCountDisable) [*2] |-> !oscStable;
    endproperty
    a_stab_low: assert property (p_stab_low) else $error("stable");
    property p_lock_drop;
        loopReset || loopPowerDown || oscPowerDown |=> !loopLocked;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("locked");
    property p_lock_evt;
        $rose(loopLocked) |-> lockEvent;
    endproperty
    a_lock_evt: assert property (p_lock_evt) else $error("no event");
    // Window of three leaves slack over the two-edge write-to-output path
    property p_osc_imm;
        csrWr && regWrData[2] && clockModeBit && !oscPowerDown
            |-> ##[1:3] oscPowerDown;
    endproperty
    a_osc_imm: assert property (p_osc_imm) else $error("osc not down");
    property p_osc_idle;
        !clockModeBit && !clockIdleStatus && !oscPowerDown |=> !oscPowerDown;
    endproperty
    a_osc_idle: assert property (p_osc_idle) else $error("early down");
    property p_csr_wr;
        csrWr |=> loopModeSelect == $past(regWrData[0])
            && loopPowerDown == $past(regWrData[1])
            && loopReset == $past(regWrData[3]);
    endproperty
    a_csr_wr: assert property (p_csr_wr) else $error("ctl");
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
    import pll_ctrl_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [15:0] regWrData = 16'h0000;
    logic        clockModeBit = 1'b1;
    logic        clockIdleStatus = 1'b0;
    logic        testMode = 1'b0;
    logic        oscCountDisable = 1'b0;
    logic [15:0] regRdData;
    logic        regRdValid, loopReset, loopPowerDown, oscPowerDown;
    logic        loopModeSelect, multiplierLegal, oscStable;
    logic        loopLocked, lockEvent;
    logic [4:0]  multiplierSelect;
    logic [15:0] expQ[$];
    int          failCount = 0;
    int          compares = 0;
    always #5 clk = ~clk;
    // Short counts keep the run brief; expectations follow them
    pll_control_status_multiplier #(.STABLE_CYCLES(8), .LOCK_CYCLES(4))
    i_pll_control_status_multiplier (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .clockModeBit(clockModeBit),
        .clockIdleStatus(clockIdleStatus), .testMode(testMode),
        .oscCountDisable(oscCountDisable), .loopReset(loopReset),
        .loopPowerDown(loopPowerDown), .oscPowerDown(oscPowerDown),
        .loopModeSelect(loopModeSelect), .multiplierSelect(multiplierSelect),
        .multiplierLegal(multiplierLegal), .oscStable(oscStable),
        .loopLocked(loopLocked), .lockEvent(lockEvent));
    task automatic complete_run;
        if (failCount == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] s,
                         input logic [15:0] e);
        compares++;
        if (s !== e) begin
            failCount++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Junk in reserved bits must never reach the stored fields
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] m;
        m = (a == MULT_OFFSET) ? 16'hFFE0 : 16'hFF90;
        tick(1);
        regAddr = a;
        regWrData = d | (16'($urandom) & m);
        regWrEn = 1'b1;
        tick(1);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        tick(1);
        expQ.push_back(e);
        regAddr = a;
        regRdEn = 1'b1;
        tick(1);
        regRdEn = 1'b0;
    endtask
    always @(posedge clk) begin
        if (regRdValid === 1'b1) begin
            if (expQ.size() == 0) check("extra", 16'h0001, 16'h0000);
            else check("regRdData", regRdData, expQ.pop_front());
        end
    end
    initial begin
        void'($urandom(32'hE0B3));
        tick(12);
        nrst = 1'b1;
        check("loopReset", 16'(loopReset), 16'h0001);
        rd(CSR_OFFSET, 16'h0008);
        rd(MULT_OFFSET, 16'h0000);
        for (int c = 0; c < 32; c++) begin
            wr(MULT_OFFSET, 16'(c));
            check("legal", 16'(multiplierLegal), 16'(c>1 && c<16));
            check("mult", 16'(multiplierSelect), 16'(c));
            rd(MULT_OFFSET, 16'(c));
        end
        wr(16'h1C84, 16'hFFFF);
        rd(16'h1C82, 16'h0000);
        rd(CSR_OFFSET, 16'h0048);
        wr(CSR_OFFSET, 16'h0008);
        wr(MULT_OFFSET, 16'h000A);
        tick(100);
        wr(CSR_OFFSET, 16'h0000);
        rd(CSR_OFFSET, 16'h0040);
        for (int n = 0; n < 50 && loopLocked !== 1'b1; n++) tick(1);
        check("locked", 16'(loopLocked), 16'h0001);
        check("lockEvent", 16'(lockEvent), 16'h0001);
        if (loopLocked !== 1'b1) complete_run();
        wr(CSR_OFFSET, 16'h0001);
        check("lockEvent", 16'(lockEvent), 16'h0000);
        check("mode", 16'(loopModeSelect), 16'h0001);
        rd(CSR_OFFSET, 16'h0061);
        wr(CSR_OFFSET, 16'h0002);
        tick(2);
        rd(CSR_OFFSET, 16'h0042);
        wr(CSR_OFFSET, 16'h0004);
        tick(3);
        check("oscDown", 16'(oscPowerDown), 16'h0001);
        rd(CSR_OFFSET, 16'h0004);
        for (int m = 0; m < 2; m++) begin
            testMode = (m == 0);
            oscCountDisable = (m == 1);
            tick(2);
            rd(CSR_OFFSET, 16'h0044);
        end
        testMode = 1'b0;
        oscCountDisable = 1'b0;
        wr(CSR_OFFSET, 16'h0000);
        tick(30);
        check("stable", 16'(oscStable), 16'h0001);
        clockModeBit = 1'b0;
        wr(CSR_OFFSET, 16'h0004);
        tick(5);
        check("oscDown", 16'(oscPowerDown), 16'h0000);
        clockIdleStatus = 1'b1;
        tick(3);
        check("oscDown", 16'(oscPowerDown), 16'h0001);
        clockIdleStatus = 1'b0;
        tick(4);
        check("pending", 16'(expQ.size()), 16'h0000);
        complete_run();
    end
endmodule
bind pll_control_status_multiplier pll_ctrl_chk i_pll_ctrl_chk (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .clockModeBit(clockModeBit), .clockIdleStatus(clockIdleStatus),
    .testMode(testMode), .oscCountDisable(oscCountDisable),
    .loopReset(loopReset), .loopPowerDown(loopPowerDown),
    .oscPowerDown(oscPowerDown), .loopModeSelect(loopModeSelect),
    .oscStable(oscStable), .loopLocked(loopLocked), .lockEvent(lockEvent));
